// ==== include/phase_cal_pkg.sv ====
// Holds the constants, field layouts and carrier types of the phase
// calibration and power sign register bank.
// Assumes one clock, a synchronous reset and an AXI4-Lite register bus.
//
// What this block does
// - Calibration value is 10 bits, resets to zero
// - Lagging current uses values 512 through 575
// - Values 384-511 act like 256-383
// - Values 576-1023 act like 256-383, repeating every 128
// - Upper six calibration bits reserved, no effect
// - Bits 0-2: per-phase active power negative
// - Bits 4-6: per-phase fundamental reactive negative
// - Bit 3: first pulse path sum negative
// - Bit 7: second pulse path sum negative
// - Bit 8: third pulse path sum negative
// - Sign bits 15:9 always read zero
// - Source codes select summed power type
package phase_cal_pkg;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam int          IDX_W          = 16;
  localparam logic [15:0] IDX_PHASE_A    = 16'hE614;
  localparam logic [15:0] IDX_PHASE_B    = 16'hE615;
  localparam logic [15:0] IDX_PHASE_C    = 16'hE616;
  localparam logic [15:0] IDX_SIGN       = 16'hE617;
  localparam logic [15:0] IDX_CONFIG     = 16'hE620;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'hE621;
  localparam logic [15:0] IDX_IRQ_MASK   = 16'hE622;

  // ---------------------------------------------------------------
  // Compensation value layout and folding points
  // ---------------------------------------------------------------
  localparam int          COMP_W     = 10;
  localparam int          FOLD_MOD_W = 7;
  localparam logic [9:0]  COMP_RESET = 10'h000;
  localparam logic [9:0]  FOLD_BASE  = 10'h100;
  localparam logic [9:0]  FOLD1_LO   = 10'h180;
  localparam logic [9:0]  LAG_LO     = 10'h200;
  localparam logic [9:0]  FOLD2_LO   = 10'h240;

  // ---------------------------------------------------------------
  // Sign status layout
  // ---------------------------------------------------------------
  localparam int         SIGN_W       = 9;
  localparam int         SIGN_ACT_A   = 0;
  localparam int         SIGN_REACT_A = 4;
  localparam int         SIGN_PATH1   = 3;
  localparam int         SIGN_PATH2   = 7;
  localparam int         SIGN_PATH3   = 8;
  localparam logic [8:0] SIGN_RESET   = 9'h000;

  // ---------------------------------------------------------------
  // Configuration register layout
  // ---------------------------------------------------------------
  localparam int          CFG_SRC_LSB   = 0;
  localparam int          CFG_TERM_LSB  = 9;
  localparam int          CFG_ACC_SEL   = 18;
  localparam int          CFG_W         = 19;
  localparam logic [18:0] CFG_RESET     = 19'h3FEA0;

  // ---------------------------------------------------------------
  // Summed power source codes
  // ---------------------------------------------------------------
  localparam logic [2:0] SRC_TOTAL_ACTIVE  = 3'h0;
  localparam logic [2:0] SRC_APPARENT      = 3'h2;
  localparam logic [2:0] SRC_FUND_ACTIVE   = 3'h3;
  localparam logic [2:0] SRC_FUND_REACTIVE = 3'h4;

  // ---------------------------------------------------------------
  // Bus answers
  // ---------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  localparam int POWER_W = 24;

  typedef struct packed {
    logic signed [POWER_W-1:0] total_active;
    logic signed [POWER_W-1:0] fund_active;
    logic signed [POWER_W-1:0] apparent;
    logic signed [POWER_W-1:0] fund_reactive;
  } phase_power_type;

  typedef enum logic [1:0] {
    WR_COLLECT = 2'b01,
    WR_RESP    = 2'b10
  } wr_state_type;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_RESP = 2'b10
  } rd_state_type;

endpackage

// ==== rtl/comp_fold.sv ====
// Holds the folding of a raw compensation value onto the value the
// phase correction actually uses.
// Assumes a purely combinational use; the caller registers the result.
`timescale 1ns/100ps

module comp_fold
  import phase_cal_pkg::*;
(
  input  wire logic [COMP_W-1:0] raw,  // Value as written
  output logic      [COMP_W-1:0] eff   // Value the correction uses
);

  logic [FOLD_MOD_W-1:0] off2;  // Offset above the upper fold point

  assign off2 = FOLD_MOD_W'(raw - FOLD2_LO);

  // Fold reserved ranges onto their working equivalents
  always_comb begin
    if (raw >= FOLD2_LO) begin
      eff = FOLD_BASE + COMP_W'(off2);
    end else if (raw >= LAG_LO) begin
      eff = raw;
    end else if (raw >= FOLD1_LO) begin
      eff = raw - (FOLD1_LO - FOLD_BASE);
    end else begin
      eff = raw;
    end
  end

endmodule

// ==== rtl/phase_cal_regs.sv ====
// Holds the phase calibration registers, the power sign status, its
// change interrupt and the AXI4-Lite slave that reaches them.
// Assumes the metering datapath presents per-phase powers on the same
// clock with a one-cycle valid strobe as each computation completes.
`timescale 1ns/100ps

module phase_cal_regs
  import phase_cal_pkg::*;
#(
  parameter int ADDR_W = 18
)
(
  input  wire logic                    clk,            // System clock
  input  wire logic                    rst,            // Sync reset, high
  input  wire logic [ADDR_W-1:0]       s_axi_awaddr,   // Write address
  input  wire logic [2:0]              s_axi_awprot,   // Unused
  input  wire logic                    s_axi_awvalid,  // Write address valid
  output logic                         s_axi_awready,  // Write address ready
  input  wire logic [31:0]             s_axi_wdata,    // Write data
  input  wire logic [3:0]              s_axi_wstrb,    // Byte enables
  input  wire logic                    s_axi_wvalid,   // Write data valid
  output logic                         s_axi_wready,   // Write data ready
  output logic [1:0]                   s_axi_bresp,    // Write answer
  output logic                         s_axi_bvalid,   // Write answer valid
  input  wire logic                    s_axi_bready,   // Write answer ready
  input  wire logic [ADDR_W-1:0]       s_axi_araddr,   // Read address
  input  wire logic [2:0]              s_axi_arprot,   // Unused
  input  wire logic                    s_axi_arvalid,  // Read address valid
  output logic                         s_axi_arready,  // Read address ready
  output logic [31:0]                  s_axi_rdata,    // Read data
  output logic [1:0]                   s_axi_rresp,    // Read answer
  output logic                         s_axi_rvalid,   // Read data valid
  input  wire logic                    s_axi_rready,   // Read data ready
  input  wire phase_power_type [2:0]   phase_power,    // Powers, C..A
  input  wire logic                    power_valid,    // New powers strobe
  output logic [2:0][COMP_W-1:0]       comp_effective, // Folded values
  output logic [SIGN_W-1:0]            power_sign,     // Sign status
  output logic                         irq             // Interrupt level
);

  // ---------------------------------------------------------------
  // Elaboration check
  // ---------------------------------------------------------------
  localparam int AI_W  = ADDR_W - 2;
  localparam int SUM_W = POWER_W + 2;

  if (ADDR_W < IDX_W + 2) begin : g_bad_addr
    $error("ADDR_W too narrow for the register indices");
  end

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] val,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = val[b*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic hit(input logic [AI_W-1:0] idx,
                               input logic [15:0]     reg_idx);
    return idx == AI_W'(reg_idx);
  endfunction

  // Chosen power of one phase for a source code
  function automatic logic signed [POWER_W-1:0] pick(
      input phase_power_type p, input logic [2:0] src);
    case (src)
      SRC_APPARENT:      pick = p.apparent;
      SRC_FUND_ACTIVE:   pick = p.fund_active;
      SRC_FUND_REACTIVE: pick = p.fund_reactive;
      default:           pick = p.total_active;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  wr_state_type                  wr_state_q, wr_state_d;
  rd_state_type                  rd_state_q, rd_state_d;
  logic                          aw_held_q, aw_held_d;
  logic                          w_held_q, w_held_d;
  logic [AI_W-1:0]               wr_idx_q, wr_idx_d;
  logic [31:0]                   wr_data_q, wr_data_d;
  logic [3:0]                    wr_strb_q, wr_strb_d;
  logic                          awready_q, awready_d;
  logic                          wready_q, wready_d;
  logic                          bvalid_q, bvalid_d;
  logic [1:0]                    bresp_q, bresp_d;
  logic                          arready_q, arready_d;
  logic                          rvalid_q, rvalid_d;
  logic [1:0]                    rresp_q, rresp_d;
  logic [31:0]                   rdata_q, rdata_d;
  logic [2:0][COMP_W-1:0]        cal_q, cal_d;
  logic [2:0][COMP_W-1:0]        eff_q, fold;
  logic [CFG_W-1:0]              cfg_q, cfg_d;
  logic [SIGN_W-1:0]             mask_q, mask_d;
  logic [SIGN_W-1:0]             stat_q, stat_d;
  logic                          irq_q, irq_d;
  logic [SIGN_W-1:0]             sign_q, sign_d;
  logic [2:0]                    path_neg;
  logic                          wr_fire, rd_fire;
  logic [AI_W-1:0]               rd_idx;
  logic                          wr_known, rd_known;

  assign wr_fire = (wr_state_q == WR_COLLECT) && aw_held_q && w_held_q;
  assign rd_fire = s_axi_arvalid && arready_q;
  assign rd_idx  = s_axi_araddr[ADDR_W-1:2];

  // Address decode shared by both channels
  assign wr_known = hit(wr_idx_q, IDX_PHASE_A) || hit(wr_idx_q, IDX_PHASE_B)
                 || hit(wr_idx_q, IDX_PHASE_C) || hit(wr_idx_q, IDX_SIGN)
                 || hit(wr_idx_q, IDX_CONFIG) || hit(wr_idx_q, IDX_IRQ_STATUS)
                 || hit(wr_idx_q, IDX_IRQ_MASK);
  assign rd_known = hit(rd_idx, IDX_PHASE_A) || hit(rd_idx, IDX_PHASE_B)
                 || hit(rd_idx, IDX_PHASE_C) || hit(rd_idx, IDX_SIGN)
                 || hit(rd_idx, IDX_CONFIG) || hit(rd_idx, IDX_IRQ_STATUS)
                 || hit(rd_idx, IDX_IRQ_MASK);

  // ---------------------------------------------------------------
  // Bus channels
  // ---------------------------------------------------------------
  // Collect address and data in either order, answer after both
  always_comb begin
    wr_state_d = wr_state_q;
    aw_held_d  = aw_held_q;
    w_held_d   = w_held_q;
    wr_idx_d   = wr_idx_q;
    wr_data_d  = wr_data_q;
    wr_strb_d  = wr_strb_q;
    bvalid_d   = bvalid_q;
    bresp_d    = bresp_q;
    rd_state_d = rd_state_q;
    rvalid_d   = rvalid_q;
    rresp_d    = rresp_q;
    rdata_d    = rdata_q;
    arready_d  = arready_q;
    case (wr_state_q)
      WR_COLLECT: begin
        if (s_axi_awvalid && awready_q) begin
          aw_held_d = 1'b1;
          wr_idx_d  = s_axi_awaddr[ADDR_W-1:2];
        end
        if (s_axi_wvalid && wready_q) begin
          w_held_d  = 1'b1;
          wr_data_d = s_axi_wdata;
          wr_strb_d = s_axi_wstrb;
        end
        if (wr_fire) begin
          aw_held_d  = 1'b0;
          w_held_d   = 1'b0;
          bvalid_d   = 1'b1;
          bresp_d    = wr_known ? RESP_OKAY : RESP_SLVERR;
          wr_state_d = WR_RESP;
        end
      end
      WR_RESP: begin
        if (s_axi_bready) begin
          bvalid_d   = 1'b0;
          wr_state_d = WR_COLLECT;
        end
      end
      default: begin
        wr_state_d = WR_COLLECT;
      end
    endcase
    awready_d = (wr_state_d == WR_COLLECT) && !aw_held_d;
    wready_d  = (wr_state_d == WR_COLLECT) && !w_held_d;
    case (rd_state_q)
      RD_IDLE: begin
        arready_d = 1'b1;
        if (rd_fire) begin
          rvalid_d   = 1'b1;
          arready_d  = 1'b0;
          rresp_d    = rd_known ? RESP_OKAY : RESP_SLVERR;
          rdata_d    = '0;
          rd_state_d = RD_RESP;
          if (hit(rd_idx, IDX_PHASE_A)) rdata_d = 32'(cal_q[0]);
          if (hit(rd_idx, IDX_PHASE_B)) rdata_d = 32'(cal_q[1]);
          if (hit(rd_idx, IDX_PHASE_C)) rdata_d = 32'(cal_q[2]);
          if (hit(rd_idx, IDX_SIGN))    rdata_d = 32'(sign_q);
          if (hit(rd_idx, IDX_CONFIG))  rdata_d = 32'(cfg_q);
          if (hit(rd_idx, IDX_IRQ_STATUS)) rdata_d = 32'(stat_q);
          if (hit(rd_idx, IDX_IRQ_MASK))   rdata_d = 32'(mask_q);
        end
      end
      RD_RESP: begin
        if (s_axi_rready) begin
          rvalid_d   = 1'b0;
          arready_d  = 1'b1;
          rd_state_d = RD_IDLE;
        end
      end
      default: begin
        rd_state_d = RD_IDLE;
        arready_d  = 1'b1;
      end
    endcase
  end

  // Register the bus channels
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_state_q <= WR_COLLECT;
      aw_held_q  <= 1'b0;
      w_held_q   <= 1'b0;
      wr_idx_q   <= '0;
      wr_data_q  <= 32'h00000000;
      wr_strb_q  <= 4'h0;
      awready_q  <= 1'b0;
      wready_q   <= 1'b0;
      bvalid_q   <= 1'b0;
      bresp_q    <= RESP_OKAY;
      rd_state_q <= RD_IDLE;
      arready_q  <= 1'b0;
      rvalid_q   <= 1'b0;
      rresp_q    <= RESP_OKAY;
      rdata_q    <= 32'h00000000;
    end else begin
      wr_state_q <= wr_state_d;
      aw_held_q  <= aw_held_d;
      w_held_q   <= w_held_d;
      wr_idx_q   <= wr_idx_d;
      wr_data_q  <= wr_data_d;
      wr_strb_q  <= wr_strb_d;
      awready_q  <= awready_d;
      wready_q   <= wready_d;
      bvalid_q   <= bvalid_d;
      bresp_q    <= bresp_d;
      rd_state_q <= rd_state_d;
      arready_q  <= arready_d;
      rvalid_q   <= rvalid_d;
      rresp_q    <= rresp_d;
      rdata_q    <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // Software registers and interrupt
  // ---------------------------------------------------------------
  // Writes, read-to-clear status where a new change wins, mask gating
  always_comb begin
    logic [31:0] m;
    m      = 32'h00000000;
    cal_d  = cal_q;
    cfg_d  = cfg_q;
    mask_d = mask_q;
    stat_d = stat_q;
    if (wr_fire) begin
      if (hit(wr_idx_q, IDX_PHASE_A)) begin
        m        = merge(32'(cal_q[0]), wr_data_q, wr_strb_q);
        cal_d[0] = m[COMP_W-1:0];
      end
      if (hit(wr_idx_q, IDX_PHASE_B)) begin
        m        = merge(32'(cal_q[1]), wr_data_q, wr_strb_q);
        cal_d[1] = m[COMP_W-1:0];
      end
      if (hit(wr_idx_q, IDX_PHASE_C)) begin
        m        = merge(32'(cal_q[2]), wr_data_q, wr_strb_q);
        cal_d[2] = m[COMP_W-1:0];
      end
      if (hit(wr_idx_q, IDX_CONFIG)) begin
        m     = merge(32'(cfg_q), wr_data_q, wr_strb_q);
        cfg_d = m[CFG_W-1:0];
      end
      if (hit(wr_idx_q, IDX_IRQ_MASK)) begin
        m      = merge(32'(mask_q), wr_data_q, wr_strb_q);
        mask_d = m[SIGN_W-1:0];
      end
    end
    if (rd_fire && hit(rd_idx, IDX_IRQ_STATUS)) begin
      stat_d = '0;
    end
    if (power_valid) begin
      stat_d = stat_d | (sign_d ^ sign_q);
    end
    irq_d = |(stat_d & mask_d);
  end

  // Register the software state
  always_ff @(posedge clk) begin
    if (rst) begin
      cal_q  <= {3{COMP_RESET}};
      eff_q  <= {3{COMP_RESET}};
      cfg_q  <= CFG_RESET;
      mask_q <= '0;
      stat_q <= '0;
      irq_q  <= 1'b0;
    end else begin
      cal_q  <= cal_d;
      eff_q  <= fold;
      cfg_q  <= cfg_d;
      mask_q <= mask_d;
      stat_q <= stat_d;
      irq_q  <= irq_d;
    end
  end

  // ---------------------------------------------------------------
  // Per-phase folding and per-path sums
  // ---------------------------------------------------------------
  for (genvar i = 0; i < 3; i++) begin : g_chan
    logic signed [SUM_W-1:0] sum;
    logic [2:0]              src;
    logic [2:0]              term;

    assign src  = cfg_q[CFG_SRC_LSB + 3*i +: 3];
    assign term = cfg_q[CFG_TERM_LSB + 3*i +: 3];

    // Fold this phase's calibration value
    comp_fold u_fold (
      .raw (cal_q[i]),
      .eff (fold[i])
    );

    // Sum the selected powers of the selected phases
    always_comb begin
      sum = '0;
      for (int ph = 0; ph < 3; ph++) begin
        if (term[ph]) begin
          sum = sum + SUM_W'(pick(phase_power[ph], src));
        end
      end
    end

    assign path_neg[i] = sum[SUM_W-1];
  end

  // ---------------------------------------------------------------
  // Sign status
  // ---------------------------------------------------------------
  // Recompute every sign as each power computation completes
  always_comb begin
    sign_d = sign_q;
    if (power_valid) begin
      for (int ph = 0; ph < 3; ph++) begin
        sign_d[SIGN_ACT_A + ph] = cfg_q[CFG_ACC_SEL]
                                ? phase_power[ph].fund_active[POWER_W-1]
                                : phase_power[ph].total_active[POWER_W-1];
        sign_d[SIGN_REACT_A + ph] =
            phase_power[ph].fund_reactive[POWER_W-1];
      end
      sign_d[SIGN_PATH1] = path_neg[0];
      sign_d[SIGN_PATH2] = path_neg[1];
      sign_d[SIGN_PATH3] = path_neg[2];
    end
  end

  // Register the signs; software has no write path to them
  always_ff @(posedge clk) begin
    if (rst) begin
      sign_q <= SIGN_RESET;
    end else begin
      sign_q <= sign_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign s_axi_awready  = awready_q;
  assign s_axi_wready   = wready_q;
  assign s_axi_bvalid   = bvalid_q;
  assign s_axi_bresp    = bresp_q;
  assign s_axi_arready  = arready_q;
  assign s_axi_rvalid   = rvalid_q;
  assign s_axi_rresp    = rresp_q;
  assign s_axi_rdata    = rdata_q;
  assign comp_effective = eff_q;
  assign power_sign     = sign_q;
  assign irq            = irq_q;

endmodule

// ==== verif/phase_cal_monitor.sv ====
// Concurrent checks on the calibration and power sign register bank.
// Assumes it is bound into phase_cal_regs and sees only its ports.
`timescale 1ns/100ps

module phase_cal_monitor
  import phase_cal_pkg::*;
(
  input wire logic                   clk,            // Clock
  input wire logic                   rst,            // Sync reset
  input wire logic                   s_axi_awvalid,  // Write address valid
  input wire logic                   s_axi_awready,  // Write address ready
  input wire logic                   s_axi_wvalid,   // Write data valid
  input wire logic                   s_axi_wready,   // Write data ready
  input wire logic                   s_axi_bvalid,   // Write answer valid
  input wire logic [1:0]             s_axi_bresp,    // Write answer
  input wire logic                   s_axi_arvalid,  // Read address valid
  input wire logic                   s_axi_arready,  // Read address ready
  input wire logic                   s_axi_rvalid,   // Read data valid
  input wire logic [1:0]             s_axi_rresp,    // Read answer
  input wire phase_power_type [2:0]  phase_power,    // Powers
  input wire logic                   power_valid,    // Powers strobe
  input wire logic [2:0][COMP_W-1:0] comp_effective, // Folded values
  input wire logic [SIGN_W-1:0]      power_sign      // Sign status
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Sign bits of the presented powers, C..A
  wire logic [2:0] tot_msb = {phase_power[2].total_active[POWER_W-1],
    phase_power[1].total_active[POWER_W-1], phase_power[0].total_active[POWER_W-1]};
  wire logic [2:0] fa_msb = {phase_power[2].fund_active[POWER_W-1],
    phase_power[1].fund_active[POWER_W-1], phase_power[0].fund_active[POWER_W-1]};
  wire logic [2:0] re_msb = {phase_power[2].fund_reactive[POWER_W-1],
    phase_power[1].fund_reactive[POWER_W-1], phase_power[0].fund_reactive[POWER_W-1]};

  // A folded value never lands in the aliased ranges
  function automatic logic legal(input logic [COMP_W-1:0] v);
    return (v < FOLD1_LO) || (v >= LAG_LO && v < FOLD2_LO);
  endfunction

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_react_sign_track:
    assert property (power_valid |=> power_sign[6:4] == $past(re_msb))
    else $error("reactive sign bits wrong");
  a_active_sign_c:
    assert property (power_valid && tot_msb[2] == fa_msb[2]
      |=> power_sign[2] == $past(tot_msb[2])) else $error("phase C active sign wrong");
  a_sign_hold_idle:
    assert property (!power_valid |=> $stable(power_sign))
    else $error("sign status moved without new powers");
  a_reset_values_zero:
    assert property ($fell(rst) |-> power_sign == '0 && comp_effective == '0)
    else $error("values not zero after reset");
  a_fold_range_legal:
    assert property (legal(comp_effective[0]) && legal(comp_effective[1])
      && legal(comp_effective[2])) else $error("folded value out of range");
  a_cal_change_cause:
    assert property (!$stable(comp_effective) |-> $past(s_axi_bvalid))
    else $error("calibration changed without a write");
  a_write_answer_time:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_read_answer_time:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");

  c_power_update: cover property (power_valid ##1 power_sign != '0);
  c_write_refused: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  c_read_refused: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule

bind phase_cal_regs phase_cal_monitor u_monitor (.clk, .rst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rresp, .phase_power,
  .power_valid, .comp_effective, .power_sign);

// ==== verif/testbench.sv ====
// Self-checking bench for the calibration and power sign register bank.
// Assumes a 25 MHz clock and registers at four times their index.
`timescale 1ns/100ps

module testbench
  import phase_cal_pkg::*;
;
  logic                   clk, rst, power_valid, irq;
  logic                   s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                   s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                   s_axi_rvalid, s_axi_rready;
  logic [17:0]            s_axi_awaddr, s_axi_araddr;
  logic [31:0]            s_axi_wdata, s_axi_rdata, rd_data;
  logic [1:0]             s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
  phase_power_type [2:0]  phase_power;
  logic [2:0][COMP_W-1:0] comp_effective;
  logic [SIGN_W-1:0]      power_sign;
  logic [9:0]             cal_v [7];
  logic [9:0]             eff_x [3];
  logic [9:0]             eff_v [7];
  logic [2:0]             code [5];
  int                     num_errors, samples_checked;
  int                     cycles = 0;

  phase_cal_regs u_dut (.clk, .rst, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .phase_power, .power_valid, .comp_effective, .power_sign, .irq);

  // ----------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      num_errors++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    if (num_errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Write cycle
  task automatic wr(input logic [17:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    wr_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // Read cycle
  task automatic rd(input logic [17:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd_data = s_axi_rdata;
    rd_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // One-cycle strobe of new powers
  task automatic pulse();
    @(posedge clk);
    power_valid <= 1'b1;
    @(posedge clk);
    power_valid <= 1'b0;
    @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h8;
    {s_axi_arvalid, s_axi_rready, power_valid} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    phase_power[0] = '{-24'sh5, 24'sh1, 24'sh2, -24'sh3};
    phase_power[1] = '{24'sh1, -24'sh1, 24'sh1, 24'sh4};
    phase_power[2] = '{24'sh1, 24'sh0, -24'shA, -24'sh2};
    cal_v = '{10'h17F, 10'h1FF, 10'h200, 10'h23F, 10'h3FF, 10'h180, 10'h240};
    eff_v = '{10'h17F, 10'h17F, 10'h200, 10'h23F, 10'h13F, 10'h100, 10'h100};
    eff_x = '{10'h0, 10'h0, 10'h0};
    code = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h1};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      rd({16'(IDX_PHASE_A + k), 2'b00});
      chk(rd_data, 32'h0);
    end
    // Calibration values with reserved bits set, across the fold points
    for (int i = 0; i < 7; i++) begin
      wr({16'(IDX_PHASE_A + i % 3), 2'b00}, {22'h3FFFFF, cal_v[i]});
      eff_x[i % 3] = eff_v[i];
      rd({16'(IDX_PHASE_A + i % 3), 2'b00});
      chk(rd_data, {22'h0, cal_v[i]});
      for (int k = 0; k < 3; k++)
        chk({22'h0, comp_effective[k]}, {22'h0, eff_x[k]});
    end
    // Signs under reset configuration; sign register ignores writes
    pulse();
    chk({23'h0, power_sign}, 32'h1D9);
    chk({31'h0, irq}, 32'h0);
    wr({IDX_SIGN, 2'b00}, 32'hFFFFFFFF);
    rd({IDX_SIGN, 2'b00});
    chk(rd_data, 32'h1D9);
    wr({16'hE618, 2'b00}, 32'h1);
    chk({30'h0, wr_resp}, {30'h0, RESP_SLVERR});
    rd({16'hE618, 2'b00});
    chk({30'h0, rd_resp}, {30'h0, RESP_SLVERR});
    // Interrupt unmasked, then cleared by reading status
    wr({IDX_IRQ_MASK, 2'b00}, 32'h1FF);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    rd({IDX_IRQ_STATUS, 2'b00});
    chk(rd_data, 32'h1D9);
    rd({IDX_IRQ_STATUS, 2'b00});
    chk(rd_data, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // Every source code on the first path, phase A only
    for (int i = 0; i < 5; i++) begin
      wr({IDX_CONFIG, 2'b00}, {14'h0, 6'h3F, 3'h1, 3'h2, 3'h4, code[i]});
      pulse();
      chk({31'h0, power_sign[SIGN_PATH1]}, {31'h0, 1'(5'b11001 >> i)});
    end
    wr({IDX_CONFIG, 2'b00}, {13'h0, 1'b1, 6'h3F, 3'h1, 3'h2, 3'h4, 3'h0});
    pulse();
    chk({23'h0, power_sign}, 32'h1DA);
    complete_run();
  end
endmodule
